// ==== pswc_pkg.sv ====
// Constants and types for the power state and wake controller.
// Assumes one 25 MHz core clock and host strobes synchronous to it.
package pswc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CORE_CLK_KHZ = 25000;
	localparam int WAKE_PULSE_MS = 50;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * CORE_CLK_KHZ;
	localparam int READY_MAX_MS = 2;
	localparam int READY_MAX_CYC = READY_MAX_MS * CORE_CLK_KHZ;
	localparam int RESTART_CYC_DEF = 8;
	localparam int RESTART_CYC_MAX = 32;
	localparam int PULSE_W = 21;
	localparam int RESTART_W = 6;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] PSEL_NORMAL = 2'h0;
	localparam logic [1:0] PSEL_LIGHT = 2'h1;
	localparam logic [1:0] PSEL_DEEP = 2'h2;
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_ENERGY = 2'h1;
	localparam logic [1:0] SRC_FRAME = 2'h2;

	// Gray along normal, sleep, waking; waking to normal flips both bits
	typedef enum logic [1:0] {
		ST_NORMAL = 2'h0,
		ST_LIGHT = 2'h1,
		ST_WAKE = 2'h3,
		ST_DEEP = 2'h2
	} pswc_state_type;

	typedef enum logic [1:0] {
		WR_PSEL = 2'h0,
		WR_TEST = 2'h1,
		WR_SRC_CLR = 2'h2,
		WR_IRQ_CLR = 2'h3
	} pswc_wr_type;

	typedef struct packed {
		logic rd;
		logic rd_pmctrl;
		logic wr;
		pswc_wr_type wr_kind;
		logic [1:0] wr_data;
	} pswc_req_type;

	typedef struct packed {
		logic frame_wake_en;
		logic energy_wake_en;
		logic pin_en;
		logic wake_pin_pulse_select;
		logic irq_en;
	} pswc_cfg_type;

	typedef struct packed {
		logic gen_pwrdn;
		logic energy_powerdown_enable;
		logic int_en;
		logic int_clr;
	} pswc_phy_ctl_type;

	typedef struct packed {
		logic phy;
		logic int_clk;
		logic rx_pm;
		logic mac_hif;
	} pswc_gate_type;

endpackage

// ==== pswc_top.sv ====
// Power state sequencer, wake detection, wake pin and PHY power control.
// Assumes host access strobes are one-cycle pulses synchronous to CORE_CLK.
`timescale 1ns/10ps
module pswc_top
	import pswc_pkg::*;
#(
	parameter int PULSE_CYC = WAKE_PULSE_CYC,
	parameter int RESTART_CYC = RESTART_CYC_DEF
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire pswc_req_type HOST_REQ,
	input wire pswc_cfg_type CFG,
	input wire pswc_phy_ctl_type PHY_CTL,
	input wire logic FRAME_DETECT,
	input wire logic LINE_ENERGY,
	output logic READY,
	output logic RD_OK,
	output logic RD_REFUSED,
	output logic WR_OK,
	output logic [1:0] POWER_STATE_SELECT,
	output logic [1:0] WAKE_SOURCE_STATUS,
	output logic IRQ_STATUS,
	output logic HOST_IRQ,
	output logic WAKE_PIN,
	output pswc_gate_type CLK_GATE,
	output logic PHY_POWERED,
	output logic PHY_RESET,
	output logic PHY_TX_EN,
	output logic LINE_ENERGY_PRESENT,
	output logic PHY_ENERGY_FLAG,
	output logic PHY_IRQ
);
	// ****************************************
	// Elaboration checks
	// ****************************************
	if (RESTART_CYC < 1 || RESTART_CYC > RESTART_CYC_MAX ||
		RESTART_CYC > READY_MAX_CYC) begin : g_bad_restart
		$error("RESTART_CYC out of range");
	end
	if (PULSE_CYC < 8 || PULSE_CYC >= (1 << PULSE_W)) begin : g_bad_pulse
		$error("PULSE_CYC out of range");
	end

	localparam logic [RESTART_W-1:0] RESTART_LOAD =
		RESTART_W'(RESTART_CYC - 1);
	localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC - 1);

	// ****************************************
	// Power state and host access
	// ****************************************
	pswc_state_type state_r, state_nxt;
	logic [1:0] psel_r, psel_nxt;
	logic [RESTART_W-1:0] rst_cnt_r, rst_cnt_nxt;
	logic ready_r, ready_nxt;
	logic rd_seen_r, rd_seen_nxt;
	logic rd_ok_r, rd_ref_r, wr_ok_r;
	logic rd_ok, wr_allowed, wake_wr, sleeping;
	pswc_gate_type gate_r, gate_nxt;

	always_comb begin
		sleeping = (state_r == ST_LIGHT) || (state_r == ST_DEEP);
		rd_ok = HOST_REQ.rd && (ready_r || HOST_REQ.rd_pmctrl);
		// Host keeps to the wake write while not ready
		wr_allowed = HOST_REQ.wr && rd_seen_r && ready_r;
		wake_wr = HOST_REQ.wr && HOST_REQ.wr_kind == WR_TEST && sleeping;
		state_nxt = state_r;
		psel_nxt = psel_r;
		rst_cnt_nxt = rst_cnt_r;
		rd_seen_nxt = rd_seen_r || rd_ok;
		case (state_r)
			ST_NORMAL: begin
				if (wr_allowed && HOST_REQ.wr_kind == WR_PSEL) begin
					if (HOST_REQ.wr_data == PSEL_LIGHT) begin
						state_nxt = ST_LIGHT;
						psel_nxt = PSEL_LIGHT;
					end else if (HOST_REQ.wr_data == PSEL_DEEP) begin
						// PHY energy powerdown already set by host
						state_nxt = ST_DEEP;
						psel_nxt = PSEL_DEEP;
					end
				end
			end
			ST_LIGHT, ST_DEEP: begin
				if (wake_wr) begin
					state_nxt = ST_WAKE;
					psel_nxt = PSEL_NORMAL;
					rst_cnt_nxt = RESTART_LOAD;
					rd_seen_nxt = 1'b0;
				end
			end
			ST_WAKE: begin
				if (rst_cnt_r == '0) begin
					state_nxt = ST_NORMAL;
				end else begin
					rst_cnt_nxt = rst_cnt_r - 1'b1;
				end
			end
			default: state_nxt = ST_NORMAL;
		endcase
		// Ready follows a full cycle of normal state with clocks on
		ready_nxt = (state_r == ST_NORMAL) && (state_nxt == ST_NORMAL);
		gate_nxt.phy = (state_nxt != ST_DEEP);
		gate_nxt.int_clk = (state_nxt != ST_DEEP);
		gate_nxt.rx_pm = (state_nxt != ST_DEEP);
		gate_nxt.mac_hif = (state_nxt == ST_NORMAL) ||
			(state_nxt == ST_WAKE);
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= ST_NORMAL;
			psel_r <= PSEL_NORMAL;
			rst_cnt_r <= '0;
			ready_r <= 1'b0;
			rd_seen_r <= 1'b0;
			rd_ok_r <= 1'b0;
			rd_ref_r <= 1'b0;
			wr_ok_r <= 1'b0;
			gate_r <= '1;
		end else begin
			state_r <= state_nxt;
			psel_r <= psel_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			ready_r <= ready_nxt;
			rd_seen_r <= rd_seen_nxt;
			rd_ok_r <= rd_ok;
			rd_ref_r <= HOST_REQ.rd && !rd_ok;
			wr_ok_r <= wr_allowed || wake_wr;
			gate_r <= gate_nxt;
		end
	end

	// ****************************************
	// Wake source, interrupt flag and wake pin
	// ****************************************
	logic [1:0] src_r, src_nxt;
	logic irq_r, irq_nxt, host_irq_r, host_irq_nxt;
	logic pin_r, pin_nxt, evt_r;
	logic [PULSE_W-1:0] pcnt_r, pcnt_nxt;
	logic frame_evt, energy_evt, evt, start, pme_int, pin_cond;

	always_comb begin
		frame_evt = (state_r == ST_LIGHT) && FRAME_DETECT;
		// Level sensing catches a carrier present at entry
		energy_evt = (state_r == ST_DEEP) && LINE_ENERGY;
		evt = frame_evt || energy_evt;
		start = evt && !evt_r;
		// Status survives sleep; only the host clear or an event moves it
		src_nxt = src_r;
		if (wr_allowed && HOST_REQ.wr_kind == WR_SRC_CLR) begin
			src_nxt = SRC_NONE;
		end
		if (energy_evt) begin
			src_nxt = SRC_ENERGY;
		end
		if (frame_evt) begin
			src_nxt = SRC_FRAME;
		end
		pme_int = (src_r == SRC_FRAME && CFG.frame_wake_en) ||
			(src_r == SRC_ENERGY && CFG.energy_wake_en);
		irq_nxt = irq_r;
		if (wr_allowed && HOST_REQ.wr_kind == WR_IRQ_CLR &&
			HOST_REQ.wr_data[0]) begin
			irq_nxt = 1'b0;
		end
		if (evt || pme_int) begin
			irq_nxt = 1'b1;
		end
		host_irq_nxt = irq_nxt && CFG.irq_en;
		pin_cond = CFG.pin_en && ((src_nxt == SRC_FRAME &&
			CFG.frame_wake_en) || (src_nxt == SRC_ENERGY &&
			CFG.energy_wake_en));
		pcnt_nxt = (pcnt_r != '0) ? pcnt_r - 1'b1 : pcnt_r;
		if (start) begin
			pcnt_nxt = PULSE_LOAD;
		end
		if (CFG.wake_pin_pulse_select) begin
			pin_nxt = pin_cond && (start || pcnt_r != '0);
		end else begin
			pin_nxt = pin_cond && (start || pin_r);
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			src_r <= SRC_NONE;
			irq_r <= 1'b0;
			host_irq_r <= 1'b0;
			pin_r <= 1'b0;
			evt_r <= 1'b0;
			pcnt_r <= '0;
		end else begin
			src_r <= src_nxt;
			irq_r <= irq_nxt;
			host_irq_r <= host_irq_nxt;
			pin_r <= pin_nxt;
			evt_r <= evt;
			pcnt_r <= pcnt_nxt;
		end
	end

	// ****************************************
	// PHY power control
	// ****************************************
	logic phy_pwr_r, phy_pwr_nxt, phy_rst_r, phy_rst_nxt;
	logic gen_pd_r, energy_r, eflag_r, eflag_nxt, phy_irq_r, phy_irq_nxt;

	always_comb begin
		phy_pwr_nxt = !PHY_CTL.gen_pwrdn && (!PHY_CTL.energy_powerdown_enable
			|| LINE_ENERGY);
		phy_rst_nxt = gen_pd_r && !PHY_CTL.gen_pwrdn;
		eflag_nxt = eflag_r && !PHY_CTL.int_clr;
		if (PHY_CTL.energy_powerdown_enable && LINE_ENERGY && !energy_r) begin
			eflag_nxt = 1'b1;
		end
		phy_irq_nxt = eflag_nxt && PHY_CTL.int_en;
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			phy_pwr_r <= 1'b0;
			phy_rst_r <= 1'b0;
			gen_pd_r <= 1'b0;
			energy_r <= 1'b0;
			eflag_r <= 1'b0;
			phy_irq_r <= 1'b0;
		end else begin
			phy_pwr_r <= phy_pwr_nxt;
			phy_rst_r <= phy_rst_nxt;
			gen_pd_r <= PHY_CTL.gen_pwrdn;
			energy_r <= LINE_ENERGY;
			eflag_r <= eflag_nxt;
			phy_irq_r <= phy_irq_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign READY = ready_r;
	assign RD_OK = rd_ok_r;
	assign RD_REFUSED = rd_ref_r;
	assign WR_OK = wr_ok_r;
	assign POWER_STATE_SELECT = psel_r;
	assign WAKE_SOURCE_STATUS = src_r;
	assign IRQ_STATUS = irq_r;
	assign HOST_IRQ = host_irq_r;
	assign WAKE_PIN = pin_r;
	assign CLK_GATE = gate_r;
	assign PHY_POWERED = phy_pwr_r;
	assign PHY_RESET = phy_rst_r;
	assign PHY_TX_EN = phy_pwr_r;
	assign LINE_ENERGY_PRESENT = energy_r;
	assign PHY_ENERGY_FLAG = eflag_r;
	assign PHY_IRQ = phy_irq_r;

	// ****************************************
	// Assertions
	// ****************************************
	localparam int A_RDY_MAX = 40;
	default clocking a_cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	sequence s_wake_write;
		sleeping && wake_wr;
	endsequence
	sequence s_back_ready;
		!READY [*2] ##[0:A_RDY_MAX] READY;
	endsequence
	a_light_entry: assert property (state_r == ST_NORMAL && wr_allowed &&
		HOST_REQ.wr_kind == WR_PSEL && HOST_REQ.wr_data == PSEL_LIGHT
		|=> state_r == ST_LIGHT && !READY && psel_r == PSEL_LIGHT)
		else $error("light sleep not entered");
	a_sleep_access: assert property (sleeping |-> !READY and
		(HOST_REQ.rd && !HOST_REQ.rd_pmctrl |=> RD_REFUSED))
		else $error("access allowed in sleep");
	a_write_ignored: assert property (HOST_REQ.wr && !rd_seen_r &&
		!wake_wr |=> !WR_OK && $stable(psel_r))
		else $error("write taken before read");
	a_wake_return: assert property (s_wake_write |=>
		psel_r == PSEL_NORMAL ##0 s_back_ready)
		else $error("wake write did not restore ready");
	a_frame_source: assert property (frame_evt |=> src_r == SRC_FRAME &&
		IRQ_STATUS)
		else $error("frame wake not recorded");
	a_energy_source: assert property (state_r == ST_DEEP && LINE_ENERGY
		|=> src_r == SRC_ENERGY)
		else $error("carrier wake not recorded");
	a_irq_hold: assert property (pme_int |=> IRQ_STATUS)
		else $error("interrupt flag dropped while wake persists");
	a_irq_route: assert property (HOST_IRQ == (IRQ_STATUS &&
		$past(CFG.irq_en)))
		else $error("host interrupt wrong");
	a_pin_pulse: assert property (CFG.wake_pin_pulse_select && start &&
		pin_cond |=> (WAKE_PIN || !$past(CFG.wake_pin_pulse_select &&
		pin_cond)) [*8])
		else $error("wake pulse too short");
	a_pin_off: assert property (!pin_cond |=> !WAKE_PIN)
		else $error("wake pin left active");
	a_ready_clocks: assert property ($rose(READY) |-> CLK_GATE.mac_hif &&
		state_r == ST_NORMAL)
		else $error("ready before clocks restart");
	a_deep_gates: assert property (state_r == ST_DEEP |-> !CLK_GATE.int_clk
		&& !CLK_GATE.mac_hif)
		else $error("clocks running in deep sleep");
	a_phy_reset: assert property ($fell(PHY_CTL.gen_pwrdn) |=>
		PHY_RESET ##1 !PHY_RESET)
		else $error("PHY reset pulse missing");
	a_phy_energy: assert property (PHY_CTL.energy_powerdown_enable &&
		!PHY_CTL.gen_pwrdn && $rose(LINE_ENERGY) |=> PHY_POWERED &&
		PHY_ENERGY_FLAG)
		else $error("energy return not handled");
endmodule

// ==== pswc_host.sv ====
// Host model: issues reads and writes to the power state controller.
// Assumes answers are registered on the edge that takes a request.
`timescale 1ns/10ps
module pswc_host
	import pswc_pkg::*;
(
	input wire logic CORE_CLK,
	output pswc_req_type HOST_REQ,
	input wire logic RD_OK,
	input wire logic RD_REFUSED,
	input wire logic WR_OK
);
	// ****************************************
	// Access task
	// ****************************************
	initial begin
		HOST_REQ = '0;
	end

	// Only rd_pmctrl reads and the wake write while not ready
	// A write before the first accepted read since reset or the wake write is not taken
	task automatic xfer(input logic rd, input logic pm, input logic wr,
		input pswc_wr_type kind, input logic [1:0] data,
		output logic ok, output logic refused);
		@(negedge CORE_CLK);
		HOST_REQ.rd = rd;
		HOST_REQ.rd_pmctrl = pm;
		HOST_REQ.wr = wr;
		HOST_REQ.wr_kind = kind;
		HOST_REQ.wr_data = data;
		@(negedge CORE_CLK);
		ok = rd ? RD_OK : WR_OK;
		refused = RD_REFUSED;
		HOST_REQ = '0;
	endtask
endmodule

// ==== pswc_top_tb.sv ====
// Self-checking bench for the power state and wake controller.
// Assumes the host model in pswc_host and short pulse/restart counts.
`timescale 1ns/10ps
module pswc_top_tb
	import pswc_pkg::*;
;
	localparam int P_CYC = 20;
	localparam int R_CYC = 8;
	logic CORE_CLK = 1'h0;
	logic NRST = 1'h0;
	pswc_req_type HOST_REQ;
	pswc_cfg_type CFG = '0;
	pswc_phy_ctl_type PHY_CTL = '0;
	logic FRAME_DETECT = 1'h0;
	logic LINE_ENERGY = 1'h0;
	logic READY, RD_OK, RD_REFUSED, WR_OK, IRQ_STATUS, HOST_IRQ, WAKE_PIN;
	logic [1:0] POWER_STATE_SELECT, WAKE_SOURCE_STATUS;
	pswc_gate_type CLK_GATE;
	logic PHY_POWERED, PHY_RESET, PHY_TX_EN, LINE_ENERGY_PRESENT;
	logic PHY_ENERGY_FLAG, PHY_IRQ;
	int n = 0;
	int cycles = 0;
	int n_fail = 0;
	int compares = 0;

	always #20 CORE_CLK = ~CORE_CLK;

	pswc_top #(.PULSE_CYC(P_CYC), .RESTART_CYC(R_CYC)) pswc_top_inst (
		.CORE_CLK(CORE_CLK), .NRST(NRST), .HOST_REQ(HOST_REQ), .CFG(CFG),
		.PHY_CTL(PHY_CTL), .FRAME_DETECT(FRAME_DETECT),
		.LINE_ENERGY(LINE_ENERGY), .READY(READY), .RD_OK(RD_OK),
		.RD_REFUSED(RD_REFUSED), .WR_OK(WR_OK),
		.POWER_STATE_SELECT(POWER_STATE_SELECT),
		.WAKE_SOURCE_STATUS(WAKE_SOURCE_STATUS), .IRQ_STATUS(IRQ_STATUS),
		.HOST_IRQ(HOST_IRQ), .WAKE_PIN(WAKE_PIN), .CLK_GATE(CLK_GATE),
		.PHY_POWERED(PHY_POWERED), .PHY_RESET(PHY_RESET),
		.PHY_TX_EN(PHY_TX_EN), .LINE_ENERGY_PRESENT(LINE_ENERGY_PRESENT),
		.PHY_ENERGY_FLAG(PHY_ENERGY_FLAG), .PHY_IRQ(PHY_IRQ)
	);

	pswc_host pswc_host_inst (
		.CORE_CLK(CORE_CLK), .HOST_REQ(HOST_REQ), .RD_OK(RD_OK),
		.RD_REFUSED(RD_REFUSED), .WR_OK(WR_OK)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge CORE_CLK);
	endtask

	task automatic rd(input logic pm, input logic e_ok, input logic e_rf);
		logic ok, rf;
		pswc_host_inst.xfer(1'h1, pm, 1'h0, WR_PSEL, 2'h0, ok, rf);
		check("rd_ok", e_ok, ok);
		check("rd_refused", e_rf, rf);
	endtask

	task automatic wr(input pswc_wr_type k, input logic [1:0] d,
		input logic e_ok);
		logic ok, rf;
		pswc_host_inst.xfer(1'h0, 1'h0, 1'h1, k, d, ok, rf);
		check("wr_ok", e_ok, ok);
	endtask

	// Bounded wait well inside the 2 ms limit
	task automatic wait_ready;
		n = 0;
		while (READY !== 1'h1 && n < 100) begin
			cyc(1);
			n++;
		end
		check("ready", 1'h1, READY);
		check("gates_ready", 8'hf, CLK_GATE);
	endtask

	task automatic print_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		cyc(3);
		NRST = 1'h1;
		cyc(1);
		check("ready_rst", 1'h1, READY);
		check("gates_rst", 8'hf, CLK_GATE);
		wr(WR_PSEL, PSEL_LIGHT, 1'h0);
		check("sel_noread", PSEL_NORMAL, POWER_STATE_SELECT);
		rd(1'h1, 1'h1, 1'h0);
		CFG = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
		wr(WR_PSEL, PSEL_LIGHT, 1'h1);
		check("sel_light", PSEL_LIGHT, POWER_STATE_SELECT);
		check("ready_light", 1'h0, READY);
		check("gates_light", 8'he, CLK_GATE);
		rd(1'h0, 1'h0, 1'h1);
		rd(1'h1, 1'h1, 1'h0);
		FRAME_DETECT = 1'h1;
		cyc(1);
		FRAME_DETECT = 1'h0;
		check("src_frame", SRC_FRAME, WAKE_SOURCE_STATUS);
		check("irq_frame", 1'h1, IRQ_STATUS);
		check("host_irq", 1'h1, HOST_IRQ);
		n = 0;
		while (WAKE_PIN === 1'h1 && n < 100) begin
			cyc(1);
			n++;
		end
		check("pulse_len", 8'(P_CYC), 8'(n));
		wr(WR_TEST, 2'h0, 1'h1);
		check("sel_wake", PSEL_NORMAL, POWER_STATE_SELECT);
		wait_ready();
		wr(WR_SRC_CLR, 2'h0, 1'h0);
		check("src_kept", SRC_FRAME, WAKE_SOURCE_STATUS);
		rd(1'h1, 1'h1, 1'h0);
		wr(WR_SRC_CLR, 2'h0, 1'h1);
		check("src_clr", SRC_NONE, WAKE_SOURCE_STATUS);
		check("irq_held", 1'h1, IRQ_STATUS);
		wr(WR_IRQ_CLR, 2'h1, 1'h1);
		check("irq_clr", 1'h0, IRQ_STATUS);
		// Deep sleep entered with carrier already on the line
		CFG = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
		PHY_CTL.energy_powerdown_enable = 1'h1;
		LINE_ENERGY = 1'h1;
		wr(WR_PSEL, PSEL_DEEP, 1'h1);
		check("gates_deep", 8'h0, CLK_GATE);
		cyc(1);
		check("src_energy", SRC_ENERGY, WAKE_SOURCE_STATUS);
		check("pin_energy", 1'h1, WAKE_PIN);
		cyc(P_CYC + 5);
		check("pin_static", 1'h1, WAKE_PIN);
		CFG.pin_en = 1'h0;
		cyc(1);
		check("pin_off", 1'h0, WAKE_PIN);
		check("irq_no_pin", 1'h1, HOST_IRQ);
		wr(WR_TEST, 2'h0, 1'h1);
		wait_ready();
		PHY_CTL.energy_powerdown_enable = 1'h0;
		rd(1'h1, 1'h1, 1'h0);
		wr(WR_SRC_CLR, 2'h0, 1'h1);
		// PHY power-down modes
		PHY_CTL.gen_pwrdn = 1'h1;
		cyc(1);
		check("phy_down", 1'h0, PHY_POWERED);
		PHY_CTL.gen_pwrdn = 1'h0;
		cyc(1);
		check("phy_reset", 1'h1, PHY_RESET);
		check("phy_up", 1'h1, PHY_POWERED);
		cyc(1);
		check("phy_reset_end", 1'h0, PHY_RESET);
		LINE_ENERGY = 1'h0;
		PHY_CTL.energy_powerdown_enable = 1'h1;
		PHY_CTL.int_en = 1'h1;
		PHY_CTL.int_clr = 1'h1;
		cyc(1);
		PHY_CTL.int_clr = 1'h0;
		cyc(1);
		check("flag_clr", 1'h0, PHY_ENERGY_FLAG);
		check("phy_irq_clr", 1'h0, PHY_IRQ);
		check("phy_idle", 1'h0, PHY_POWERED);
		check("phy_no_tx", 1'h0, PHY_TX_EN);
		LINE_ENERGY = 1'h1;
		cyc(1);
		check("energy_seen", 1'h1, LINE_ENERGY_PRESENT);
		check("phy_wake", 1'h1, PHY_POWERED);
		check("energy_flag", 1'h1, PHY_ENERGY_FLAG);
		cyc(1);
		check("phy_irq", 1'h1, PHY_IRQ);
		print_verdict();
	end
endmodule
